// file: hw/loopback_pkg.sv
// Shared constants, types and reset values for the loopback and link status block.
// Assumes a 10 MHz system clock and a line-side partner that exchanges one word per link frame.
package loopback_pkg;

  localparam int SAMPLE_W = 16;
  // Filter group delay modelled as whole sample periods per filter.
  localparam int FILT_TAPS = 4;
  // 0.9 dB of loss is 0.902 linear, taken here as 231/256.
  localparam logic [9:0] ATTEN_NUM = 10'h0E7;
  localparam int ATTEN_SHIFT = 8;

  localparam int CLK_FREQ_MHZ = 10;
  // Link is declared lost when no frame arrives within this time.
  localparam int LINK_TIMEOUT_US = 1000;
  localparam int LINK_TIMEOUT_CYCLES = LINK_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int TIMER_W = 16;
  // Frames needed before the link counts as established.
  localparam logic [1:0] FRAMES_TO_LOCK = 2'h2;

  // System-side silicon revision; the value is arbitrary.
  localparam logic [3:0] SYS_REV = 4'h3;

  typedef enum logic [2:0] {
    MODE_NORMAL     = 3'b000,
    MODE_STARTUP    = 3'b001,
    MODE_BYPASS     = 3'b010,
    MODE_LINK_LOOP  = 3'b011,
    MODE_PCM_ANALOG = 3'b100,
    MODE_INT_ANALOG = 3'b101
  } test_mode_t;

  typedef enum logic [1:0] {
    FS_DEFAULT = 2'b00,
    FS_PLUS3P2 = 2'b01,
    FS_PLUS6P0 = 2'b10
  } fullscale_t;

  typedef struct packed {
    logic line_powerdown_bit;
    logic sleep_powerdown_bit;
    logic filter_bypass_loopback;
    logic isolation_link_loopback;
    logic pcm_analog_loopback;
    logic hybrid_enable;
    logic fullscale_bit;
    logic enhanced_fullscale_bit;
    logic offhook_bit;
    logic dropout_mask;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{
    line_powerdown_bit: 1'b1, sleep_powerdown_bit: 1'b0, filter_bypass_loopback: 1'b0,
    isolation_link_loopback: 1'b0, pcm_analog_loopback: 1'b0, hybrid_enable: 1'b1,
    fullscale_bit: 1'b0, enhanced_fullscale_bit: 1'b0, offhook_bit: 1'b0, dropout_mask: 1'b0};

  typedef struct packed {
    logic [3:0] line_side_revision;
    logic [4:0] coarse_loop_current;
    logic [7:0] fine_loop_current;
    logic [7:0] line_voltage_field;
    logic supply_dropout;
  } line_status_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] word;
    test_mode_t mode;
  } link_down_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] word;
    line_status_t status;
  } link_up_t;

endpackage : loopback_pkg

// file: hw/loopback_test_and_link_status.sv
// System-side loopback paths, link frame detection and line status reporting.
// Assumes PCM words arrive on clk_sys with a one-cycle strobe, and that the line side sends
// link frames on link_clk spaced well apart compared with a few clk_sys cycles.
`timescale 1ns/100ps
`default_nettype none

module loopback_test_and_link_status #(
  parameter int unsigned LINK_TIMEOUT = loopback_pkg::LINK_TIMEOUT_CYCLES
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control bits
  input wire logic ctrl_wr,
  input wire loopback_pkg::ctrl_t ctrl_wdata,
  output loopback_pkg::ctrl_t ctrl_q,
  input wire logic dropout_clear,
  // PCM side
  input wire logic pcm_rx_valid,
  input wire logic [loopback_pkg::SAMPLE_W-1:0] serial_rx_in,
  output logic pcm_tx_valid,
  output logic [loopback_pkg::SAMPLE_W-1:0] serial_tx_out,
  // Isolation link, on link_clk
  input wire logic link_clk,
  output logic link_enable_out,
  output logic link_tx_valid,
  output loopback_pkg::link_down_t link_tx_data,
  input wire logic link_rx_valid,
  input wire loopback_pkg::link_up_t link_rx_data,
  // Status
  output logic link_frame_detected,
  output logic [3:0] system_side_revision,
  output logic [3:0] line_side_revision,
  output logic [4:0] coarse_loop_current,
  output logic [7:0] fine_loop_current,
  output logic signed [7:0] line_voltage_field,
  output logic dropout_detect_flag,
  output logic dropout_alert,
  output loopback_pkg::fullscale_t fullscale_level,
  output loopback_pkg::test_mode_t active_mode
);
  import loopback_pkg::*;

  function automatic logic [SAMPLE_W-1:0] atten(input logic [SAMPLE_W-1:0] x);
    logic signed [SAMPLE_W+10:0] p;
    p = $signed(x) * $signed({1'b0, ATTEN_NUM});
    return p[ATTEN_SHIFT +: SAMPLE_W];
  endfunction : atten

  ctrl_t ctrl_reg;
  test_mode_t mode;
  logic [FILT_TAPS-1:0][SAMPLE_W-1:0] tx_dly_reg;
  logic [FILT_TAPS-1:0][SAMPLE_W-1:0] rx_dly_reg;
  logic [SAMPLE_W-1:0] line_word_reg;
  line_status_t line_status_reg;
  logic [SAMPLE_W-1:0] tx_out_reg;
  logic tx_valid_reg;
  logic link_on_reg;
  link_down_t dn_hold_reg;
  logic dn_tog_reg;
  logic up_meta_reg, up_sync_reg, up_prev_reg;
  logic [1:0] frame_cnt_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic det_reg;
  logic dropout_reg;
  logic [3:0] rev_reg;
  logic [4:0] coarse_reg;
  logic [7:0] fine_reg;
  logic [7:0] volt_reg;
  // Link-domain state.
  logic en_meta_reg, en_sync_reg;
  logic dn_meta_reg, dn_sync_reg, dn_prev_reg;
  link_down_t ltx_reg;
  logic ltx_valid_reg;
  link_up_t up_hold_reg;
  logic up_tog_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= ctrl_wdata;
    end
  end

  // priority among modes
  // Several modes at once give a fixed priority here rather than a blend of paths.
  // test mode select
  wire mode_bypass = ctrl_reg.filter_bypass_loopback;
  wire mode_startup = ctrl_reg.line_powerdown_bit;
  wire mode_link = ctrl_reg.isolation_link_loopback;
  wire mode_pcm_analog_loopback = ctrl_reg.pcm_analog_loopback;
  wire mode_int = !ctrl_reg.hybrid_enable;
  assign mode = mode_bypass ? MODE_BYPASS :
                mode_startup ? MODE_STARTUP :
                mode_link ? MODE_LINK_LOOP :
                mode_pcm_analog_loopback ? MODE_PCM_ANALOG :
                mode_int ? MODE_INT_ANALOG : MODE_NORMAL;

  wire [SAMPLE_W-1:0] tx_filt_out = tx_dly_reg[FILT_TAPS-1];
  wire [SAMPLE_W-1:0] rx_filt_out = rx_dly_reg[FILT_TAPS-1];
  // line data through receive then transmit filter
  wire [SAMPLE_W-1:0] tx_filt_in = (mode == MODE_PCM_ANALOG) ? rx_filt_out : serial_rx_in;
  wire [SAMPLE_W-1:0] rx_filt_in = (mode == MODE_STARTUP) ? tx_filt_out : line_word_reg;

  logic [SAMPLE_W-1:0] tx_src;
  always_comb begin
    unique case (mode)
      MODE_BYPASS: tx_src = serial_rx_in;
      MODE_STARTUP: tx_src = atten(rx_filt_out);
      MODE_LINK_LOOP: tx_src = atten(rx_filt_out);
      MODE_PCM_ANALOG: tx_src = rx_filt_out;
      MODE_INT_ANALOG: tx_src = rx_filt_out;
      MODE_NORMAL: tx_src = rx_filt_out;
      default: tx_src = '0;
    endcase
  end

  // Sleep mode zeroes only the PCM output word; the filters, the valid strobe and the link keep running.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_dly_reg <= '0;
      rx_dly_reg <= '0;
      tx_out_reg <= '0;
      tx_valid_reg <= 1'b0;
    end else begin
      tx_valid_reg <= pcm_rx_valid;
      if (pcm_rx_valid) begin
        tx_dly_reg <= {tx_dly_reg[FILT_TAPS-2:0], tx_filt_in};
        rx_dly_reg <= {rx_dly_reg[FILT_TAPS-2:0], rx_filt_in};
        tx_out_reg <= ctrl_reg.sleep_powerdown_bit ? '0 : tx_src;
      end
    end
  end

  // link held off while powered down
  // filtered words go out over the link
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_on_reg <= 1'b0;
      dn_hold_reg <= '0;
      dn_tog_reg <= 1'b0;
    end else begin
      link_on_reg <= !ctrl_reg.line_powerdown_bit;
      if (pcm_rx_valid && link_on_reg) begin
        dn_hold_reg <= '{word: tx_filt_out, mode: mode};
        dn_tog_reg <= !dn_tog_reg;
      end
    end
  end

  // Link side: enable as a synchronised level, words by toggle handshake.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
      dn_meta_reg <= 1'b0;
      dn_sync_reg <= 1'b0;
      dn_prev_reg <= 1'b0;
      ltx_reg <= '0;
      ltx_valid_reg <= 1'b0;
      up_hold_reg <= '0;
      up_tog_reg <= 1'b0;
    end else begin
      en_meta_reg <= link_on_reg;
      en_sync_reg <= en_meta_reg;
      dn_meta_reg <= dn_tog_reg;
      dn_sync_reg <= dn_meta_reg;
      dn_prev_reg <= dn_sync_reg;
      ltx_valid_reg <= en_sync_reg && (dn_sync_reg != dn_prev_reg);
      if (dn_sync_reg != dn_prev_reg) begin
        ltx_reg <= dn_hold_reg;
      end
      if (link_rx_valid && en_sync_reg) begin
        up_hold_reg <= link_rx_data;
        up_tog_reg <= !up_tog_reg;
      end
    end
  end

  // Hold register is stable well before the toggle reaches the system side.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_meta_reg <= 1'b0;
      up_sync_reg <= 1'b0;
      up_prev_reg <= 1'b0;
      line_word_reg <= '0;
      line_status_reg <= '0;
    end else begin
      up_meta_reg <= up_tog_reg;
      up_sync_reg <= up_meta_reg;
      up_prev_reg <= up_sync_reg;
      if (up_sync_reg != up_prev_reg) begin
        line_word_reg <= up_hold_reg.word;
        line_status_reg <= up_hold_reg.status;
      end
    end
  end

  wire frame_evt = (up_sync_reg != up_prev_reg) && link_on_reg;
  wire timer_done = (timer_reg == TIMER_W'(LINK_TIMEOUT - 1));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_reg <= '0;
      timer_reg <= '0;
      det_reg <= 1'b0;
    end else if (!link_on_reg) begin
      frame_cnt_reg <= '0;
      timer_reg <= '0;
      det_reg <= 1'b0;
    end else if (frame_evt) begin
      timer_reg <= '0;
      if (frame_cnt_reg != FRAMES_TO_LOCK) begin
        frame_cnt_reg <= frame_cnt_reg + 2'h1;
      end
      if (frame_cnt_reg >= FRAMES_TO_LOCK - 2'h1) begin
        det_reg <= 1'b1;
      end
    end else if (timer_done) begin
      timer_reg <= '0;
      frame_cnt_reg <= '0;
      det_reg <= 1'b0;
    end else begin
      timer_reg <= timer_reg + TIMER_W'(1);
    end
  end

  // sticky flag, a new event beats the clear
  wire dropout_evt = det_reg && line_status_reg.supply_dropout;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dropout_reg <= 1'b0;
    end else if (dropout_evt) begin
      dropout_reg <= 1'b1;
    end else if (dropout_clear) begin
      dropout_reg <= 1'b0;
    end
  end

  wire cur_ok = det_reg && ctrl_reg.offhook_bit && !line_status_reg.supply_dropout;
  wire [4:0] coarse_next = cur_ok ? line_status_reg.coarse_loop_current : 5'h00;
  wire [7:0] fine_next = cur_ok ? line_status_reg.fine_loop_current : 8'h00;
  wire [7:0] volt_next = det_reg ? line_status_reg.line_voltage_field : 8'h00;
  wire [3:0] rev_next = det_reg ? line_status_reg.line_side_revision : 4'h0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coarse_reg <= '0;
      fine_reg <= '0;
      volt_reg <= '0;
      rev_reg <= '0;
    end else begin
      coarse_reg <= coarse_next;
      fine_reg <= fine_next;
      volt_reg <= volt_next;
      rev_reg <= rev_next;
    end
  end

  assign ctrl_q = ctrl_reg;
  assign pcm_tx_valid = tx_valid_reg;
  assign serial_tx_out = tx_out_reg;
  assign link_enable_out = en_sync_reg;
  assign link_tx_valid = ltx_valid_reg;
  assign link_tx_data = ltx_reg;
  assign link_frame_detected = det_reg;
  assign system_side_revision = SYS_REV;
  assign line_side_revision = rev_reg;
  assign coarse_loop_current = coarse_reg;
  assign fine_loop_current = fine_reg;
  // signed volts, sign bit is polarity
  assign line_voltage_field = $signed(volt_reg);
  assign dropout_detect_flag = dropout_reg;
  assign dropout_alert = dropout_reg && ctrl_reg.dropout_mask;
  assign fullscale_level = ctrl_reg.enhanced_fullscale_bit ? FS_PLUS6P0 :
                           ctrl_reg.fullscale_bit ? FS_PLUS3P2 : FS_DEFAULT;
  assign active_mode = mode;
  sequence s_powered_down;
    ctrl_reg.line_powerdown_bit;
  endsequence
  sequence s_bypass_sample;
    pcm_rx_valid && mode_bypass && !ctrl_reg.sleep_powerdown_bit;
  endsequence
  property p_pd_no_frames;
    @(posedge clk_sys) disable iff (!rst_n) s_powered_down |=> ##1 !link_frame_detected;
  endproperty
  a_pd_no_frames: assert property (p_pd_no_frames) else $error("frame flag while powered down");
  property p_bypass_echo;
    @(posedge clk_sys) disable iff (!rst_n)
      s_bypass_sample |=> pcm_tx_valid && serial_tx_out == $past(serial_rx_in);
  endproperty
  a_bypass_echo: assert property (p_bypass_echo) else $error("bypass word changed");
  property p_lock;
    @(posedge clk_sys) disable iff (!rst_n)
      frame_evt && frame_cnt_reg == 2'h1 && !timer_done |=> link_frame_detected;
  endproperty
  a_lock: assert property (p_lock) else $error("link not detected after frames");
  property p_dropout_sticky;
    @(posedge clk_sys) disable iff (!rst_n)
      dropout_evt ##1 !dropout_evt && !dropout_clear |=> dropout_detect_flag;
  endproperty
  a_dropout_sticky: assert property (p_dropout_sticky) else $error("dropout flag lost");
  property p_invalid_zero;
    @(posedge clk_sys) disable iff (!rst_n) !link_frame_detected [*2] |->
      coarse_loop_current == 5'h00 && fine_loop_current == 8'h00 && line_voltage_field == 8'sh00;
  endproperty
  a_invalid_zero: assert property (p_invalid_zero) else $error("status shown while invalid");
  property p_onhook_zero;
    @(posedge clk_sys) disable iff (!rst_n) !ctrl_reg.offhook_bit [*2] |-> coarse_loop_current == 5'h00;
  endproperty
  a_onhook_zero: assert property (p_onhook_zero) else $error("current shown on-hook");
  property p_startup_path;
    @(posedge clk_sys) disable iff (!rst_n)
      pcm_rx_valid && mode == MODE_STARTUP && !ctrl_reg.sleep_powerdown_bit |=>
      serial_tx_out == atten($past(rx_dly_reg[FILT_TAPS-1]));
  endproperty
  a_startup_path: assert property (p_startup_path) else $error("start-up loop path wrong");
  property p_normal_path;
    @(posedge clk_sys) disable iff (!rst_n)
      pcm_rx_valid && !ctrl_reg.sleep_powerdown_bit && !mode_bypass && !mode_startup &&
      !mode_link && !mode_pcm_analog_loopback && !mode_int |=> serial_tx_out == $past(rx_dly_reg[FILT_TAPS-1]);
  endproperty
  a_normal_path: assert property (p_normal_path) else $error("output not line data");
  property p_link_off;
    @(posedge clk_sys) disable iff (!rst_n)
      s_powered_down [*4] |-> !link_on_reg && !$changed(dn_tog_reg);
  endproperty
  a_link_off: assert property (p_link_off) else $error("link active while powered down");

endmodule : loopback_test_and_link_status

`default_nettype wire

// file: sim/line_side_model.sv
// Behavioural line-side partner that answers on the isolation link.
// Assumes link_clk runs free and the host side opens the link through link_enable_out.
`timescale 1ns/100ps
`default_nettype none
module line_side_model
  import loopback_pkg::*;
#(
  parameter int FRAME_GAP = 200
) (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst_n,
  // Line conditions set by the bench
  input wire loopback_pkg::line_status_t status_in,
  input wire logic [loopback_pkg::SAMPLE_W-1:0] line_word,
  // Isolation link
  input wire logic link_enable_out,
  input wire logic link_tx_valid,
  input wire loopback_pkg::link_down_t link_tx_data,
  output logic link_rx_valid,
  output loopback_pkg::link_up_t link_rx_data
);
  logic [15:0] gap_reg;
  logic [SAMPLE_W-1:0] loop_word_reg;
  test_mode_t loop_mode_reg;
  logic looping;

  assign looping = (loop_mode_reg == MODE_LINK_LOOP) || (loop_mode_reg == MODE_INT_ANALOG);

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_word_reg <= '0;
      loop_mode_reg <= MODE_NORMAL;
    end else if (link_tx_valid) begin
      loop_word_reg <= link_tx_data.word;
      loop_mode_reg <= link_tx_data.mode;
    end
  end

  // Between frames the data lines carry a changing pattern, so a stale capture shows up.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= '0;
      link_rx_valid <= 1'b0;
      link_rx_data <= '0;
    end else if (!link_enable_out) begin
      gap_reg <= '0;
      link_rx_valid <= 1'b0;
      link_rx_data <= ~link_rx_data;
    end else if (gap_reg == 16'(FRAME_GAP - 1)) begin
      gap_reg <= '0;
      link_rx_valid <= 1'b1;
      link_rx_data <= '{word: (looping ? loop_word_reg : line_word), status: status_in};
    end else begin
      gap_reg <= gap_reg + 16'h0001;
      link_rx_valid <= 1'b0;
      link_rx_data <= ~link_rx_data;
    end
  end
endmodule : line_side_model
`default_nettype wire

// file: sim/test_loopback_test_and_link_status.sv
// Self-checking bench for the loopback and link status block.
// Assumes the line_side_model partner; the link timeout is shortened for simulation.
`timescale 1ns/100ps
`default_nettype none
module test_loopback_test_and_link_status;
  import loopback_pkg::*;
  localparam int unsigned TMO = 200;
  logic clk_sys, rst_n, link_clk, ctrl_wr, dropout_clear, pcm_rx_valid, pcm_tx_valid;
  logic link_enable_out, link_tx_valid, link_rx_valid, link_frame_detected;
  logic dropout_detect_flag, dropout_alert;
  ctrl_t ctrl_wdata, ctrl_q, c;
  logic [15:0] serial_rx_in, serial_tx_out, line_word, got, wv;
  link_down_t link_tx_data;
  link_up_t link_rx_data;
  logic [3:0] system_side_revision, line_side_revision;
  logic [4:0] coarse_loop_current;
  logic [7:0] fine_loop_current;
  logic signed [7:0] line_voltage_field;
  fullscale_t fullscale_level;
  test_mode_t active_mode;
  line_status_t lstat;
  logic [15:0] w [0:11];
  integer seed, fail_count, n_tests;

  loopback_test_and_link_status #(.LINK_TIMEOUT(TMO)) DUT (.clk_sys, .rst_n, .ctrl_wr,
    .ctrl_wdata, .ctrl_q, .dropout_clear, .pcm_rx_valid, .serial_rx_in, .pcm_tx_valid,
    .serial_tx_out, .link_clk, .link_enable_out, .link_tx_valid, .link_tx_data,
    .link_rx_valid, .link_rx_data, .link_frame_detected, .system_side_revision,
    .line_side_revision, .coarse_loop_current, .fine_loop_current, .line_voltage_field,
    .dropout_detect_flag, .dropout_alert, .fullscale_level, .active_mode);

  line_side_model #(.FRAME_GAP(200)) partner (.link_clk, .rst_n, .status_in(lstat),
    .line_word, .link_enable_out, .link_tx_valid, .link_tx_data, .link_rx_valid,
    .link_rx_data);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // The link clock is offset so its edges never line up with the system clock.
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h got %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic wr(input ctrl_t v);
    @(posedge clk_sys);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= v;
    @(posedge clk_sys);
    ctrl_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic pcm(input logic [15:0] v, output logic [15:0] o);
    @(posedge clk_sys);
    pcm_rx_valid <= 1'b1;
    serial_rx_in <= v;
    @(posedge clk_sys);
    pcm_rx_valid <= 1'b0;
    #1;
    chk("pcm_tx_valid", 16'h0001, {15'h0000, pcm_tx_valid});
    o = serial_tx_out;
  endtask : pcm

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic wait_link;
    for (int i = 0; i < 2000 && link_frame_detected !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("link_frame_detected", 16'h0001, {15'h0000, link_frame_detected});
    if (link_frame_detected !== 1'b1) begin
      final_report();
    end
  endtask : wait_link

  function automatic logic [15:0] atten(input logic [15:0] x);
    logic signed [26:0] p;
    p = $signed(x) * $signed({1'b0, ATTEN_NUM});
    return p[ATTEN_SHIFT +: 16];
  endfunction : atten

  initial begin
    seed = 32'hBF86B630;
    fail_count = 0;
    n_tests = 0;
    rst_n = 1'b0;
    ctrl_wr = 1'b0;
    ctrl_wdata = CTRL_RESET;
    dropout_clear = 1'b0;
    pcm_rx_valid = 1'b0;
    serial_rx_in = 16'h0000;
    lstat = '{line_side_revision: 4'h9, coarse_loop_current: 5'h0C,
      fine_loop_current: 8'h5A, line_voltage_field: 8'hE2, supply_dropout: 1'b0};
    line_word = 16'($random(seed));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    idle(1);
    chk("ctrl_q", 16'(CTRL_RESET), 16'(ctrl_q));
    chk("frame detected", 16'h0000, {15'h0000, link_frame_detected});
    chk("active_mode", 16'(MODE_STARTUP), 16'(active_mode));
    chk("system rev", 16'(SYS_REV), 16'(system_side_revision));
    chk("line rev", 16'h0000, 16'(line_side_revision));
    chk("coarse current", 16'h0000, 16'(coarse_loop_current));
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      w[i] = 16'($random(seed));
      pcm(w[i], got);
      chk("startup out", (i >= 8) ? atten(w[(i >= 8) ? i - 8 : 0]) : 16'h0000, got);
    end
    $display("test startup done");
    c = CTRL_RESET;
    c.filter_bypass_loopback = 1'b1;
    wr(c);
    chk("active_mode", 16'(MODE_BYPASS), 16'(active_mode));
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys);
      pcm_rx_valid <= (i < 8);
      serial_rx_in <= w[i];
      #1;
      if (i > 0) begin
        chk("bypass out", w[i - 1], serial_tx_out);
      end
    end
    for (int k = 0; k < 3; k++) begin
      c = CTRL_RESET;
      c.fullscale_bit = (k == 1);
      c.enhanced_fullscale_bit = (k == 2);
      wr(c);
      chk("fullscale", 16'(k), 16'(fullscale_level));
    end
    $display("test bypass and fullscale done");
    c = CTRL_RESET;
    c.line_powerdown_bit = 1'b0;
    c.offhook_bit = 1'b1;
    wr(c);
    wait_link();
    idle(40);
    chk("active_mode", 16'(MODE_NORMAL), 16'(active_mode));
    chk("line rev", 16'(lstat.line_side_revision), 16'(line_side_revision));
    chk("coarse current", 16'(lstat.coarse_loop_current), 16'(coarse_loop_current));
    chk("fine current", 16'(lstat.fine_loop_current), 16'(fine_loop_current));
    chk("voltage", 16'($signed(lstat.line_voltage_field)), 16'(line_voltage_field));
    for (int i = 0; i < 6; i++) begin
      pcm(w[i], got);
    end
    chk("normal out", line_word, got);
    c.offhook_bit = 1'b0;
    wr(c);
    idle(40);
    chk("on-hook current", 16'h0000, 16'(coarse_loop_current));
    chk("on-hook voltage", 16'($signed(lstat.line_voltage_field)), 16'(line_voltage_field));
    c.offhook_bit = 1'b1;
    wr(c);
    lstat.coarse_loop_current = 5'h00;
    lstat.fine_loop_current = 8'h00;
    idle(40);
    chk("zero coarse", 16'h0000, 16'(coarse_loop_current));
    chk("zero fine", 16'h0000, 16'(fine_loop_current));
    $display("test link status done");
    lstat.supply_dropout = 1'b1;
    c.dropout_mask = 1'b1;
    wr(c);
    idle(40);
    chk("dropout flag", 16'h0001, {15'h0000, dropout_detect_flag});
    chk("dropout alert", 16'h0001, {15'h0000, dropout_alert});
    c.dropout_mask = 1'b0;
    wr(c);
    chk("masked alert", 16'h0000, {15'h0000, dropout_alert});
    lstat.supply_dropout = 1'b0;
    idle(40);
    chk("sticky flag", 16'h0001, {15'h0000, dropout_detect_flag});
    @(posedge clk_sys);
    dropout_clear <= 1'b1;
    @(posedge clk_sys);
    dropout_clear <= 1'b0;
    #1;
    chk("cleared flag", 16'h0000, {15'h0000, dropout_detect_flag});
    $display("test dropout done");
    for (int m = 0; m < 3; m++) begin
      // one test mode at a time
      c.isolation_link_loopback = (m == 0);
      c.pcm_analog_loopback = (m == 1);
      c.hybrid_enable = (m != 2);
      wr(c);
      wv = 16'($signed(16'($random(seed))) >>> 2);
      for (int k = 0; k < 12; k++) begin
        pcm(wv, got);
        idle(20);
      end
      chk("mode", 16'(m + 3), 16'(active_mode));
      chk("loop out", (m == 0) ? atten(wv) : ((m == 1) ? line_word : wv), got);
      chk("link word", (m == 1) ? line_word : wv, link_tx_data.word);
    end
    $display("test line loops done");
    c.sleep_powerdown_bit = 1'b1;
    wr(c);
    pcm(wv, got);
    chk("sleep out", 16'h0000, got);
    wr(CTRL_RESET);
    idle(3);
    chk("frame detected", 16'h0000, {15'h0000, link_frame_detected});
    chk("line rev", 16'h0000, 16'(line_side_revision));
    $display("test power-down done");
    final_report();
  end
endmodule : test_loopback_test_and_link_status
`default_nettype wire
